// File: pkg/interp_pkg.sv
// shared constants for the interpolating half-band and output router
// assumes a single processing clock and synchronous active-low reset
package interp_pkg;

    localparam int DW         = 22;
    localparam int NCH        = 6;
    localparam int CTL_W      = 16;
    localparam int HB_EN_BIT  = 9;
    localparam int SC_W       = 4;
    localparam int CC_W       = 3;
    localparam int CC_BIP_BIT = 2;
    localparam int RND_SHIFT  = 9;

    // fixed 10-bit taps and 11-bit centre, centre equals one
    localparam logic signed [9:0]  C_OUT = 10'sh00E;
    localparam logic signed [9:0]  C_MID = 10'sh3BE;
    localparam logic signed [9:0]  C_IN  = 10'sh135;
    localparam logic signed [10:0] C_CTR = 11'sh200;

    localparam logic signed [39:0] RND_HALF = 40'sh00_0000_0100;
    localparam logic signed [39:0] SAT_HI   = 40'sh00_001F_FFFF;
    localparam logic signed [39:0] SAT_LO   = 40'shFF_FFE0_0000;

    typedef logic [NCH-1:0][2:0] size_map_t;

    function automatic logic signed [39:0] sx(input logic [DW-1:0] x);
        sx = 40'(signed'(x));
    endfunction : sx

    function automatic logic [DW-1:0] sat(input logic signed [39:0] v);
        if (v > SAT_HI) begin
            sat = SAT_HI[DW-1:0];
        end else if (v < SAT_LO) begin
            sat = SAT_LO[DW-1:0];
        end else begin
            sat = v[DW-1:0];
        end
    endfunction : sat

endpackage : interp_pkg

// File: logic/halfband_interp.sv
// one channel of the 2x interpolating half-band filter
// assumes the feeding filter holds its sample until in_ready
`timescale 1ns/1ps
`default_nettype none
module halfband_interp (
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    input  wire logic                        enable,
    input  wire logic                        in_valid,
    input  wire logic [interp_pkg::DW-1:0]   in_i,
    input  wire logic [interp_pkg::DW-1:0]   in_q,
    output logic                             in_ready,
    output logic                             out_valid,
    output logic [interp_pkg::DW-1:0]        out_i,
    output logic [interp_pkg::DW-1:0]        out_q,
    input  wire logic                        out_ready
);

    typedef struct packed {
        logic [5:0][interp_pkg::DW-1:0] ti;
        logic [5:0][interp_pkg::DW-1:0] tq;
        logic                           pend;
        logic                           ov;
        logic                           rdy;
        logic [interp_pkg::DW-1:0]      oi;
        logic [interp_pkg::DW-1:0]      oq;
    } hb_s;

    hb_s st_q;
    hb_s st_d;
    logic acc;

    // odd phase: taps 1,3,5,7,9,11 over the six newest samples
    function automatic logic signed [39:0] odd_sum(
        input logic [5:0][interp_pkg::DW-1:0] x);
        logic signed [39:0] a;
        logic signed [39:0] b;
        logic signed [39:0] c;
        a = interp_pkg::sx(x[0]) + interp_pkg::sx(x[5]);
        b = interp_pkg::sx(x[1]) + interp_pkg::sx(x[4]);
        c = interp_pkg::sx(x[2]) + interp_pkg::sx(x[3]);
        odd_sum = a * 40'(interp_pkg::C_OUT) // RULE3
                + b * 40'(interp_pkg::C_MID) // RULE3
                + c * 40'(interp_pkg::C_IN); // RULE4
    endfunction : odd_sum

    function automatic logic [interp_pkg::DW-1:0] rnd(
        input logic signed [39:0] v);
        rnd = interp_pkg::sat((v + interp_pkg::RND_HALF)
                              >>> interp_pkg::RND_SHIFT); // RULE1
    endfunction : rnd

    always_comb begin
        st_d = st_q;
        acc = in_valid && st_q.rdy;
        if (st_q.ov && out_ready) begin
            if (st_q.pend) begin
                st_d.oi   = rnd(odd_sum(st_q.ti)); // RULE2
                st_d.oq   = rnd(odd_sum(st_q.tq)); // RULE2
                st_d.pend = 1'b0;
            end else begin
                st_d.ov = 1'b0;
            end
        end
        if (acc) begin
            st_d.ti = {st_q.ti[4:0], in_i};
            st_d.tq = {st_q.tq[4:0], in_q};
            st_d.ov = 1'b1;
            if (enable) begin // RULE7
                st_d.oi   = rnd(interp_pkg::sx(st_q.ti[2])
                                * 40'(interp_pkg::C_CTR)); // RULE4
                st_d.oq   = rnd(interp_pkg::sx(st_q.tq[2])
                                * 40'(interp_pkg::C_CTR)); // RULE4
                st_d.pend = 1'b1; // RULE5
            end else begin
                st_d.oi   = in_i; // RULE7
                st_d.oq   = in_q;
                st_d.pend = 1'b0;
            end
        end
        st_d.rdy = !st_d.ov;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign in_ready  = st_q.rdy;
    assign out_valid = st_q.ov;
    assign out_i     = st_q.oi;
    assign out_q     = st_q.oq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_acc_en;
        in_valid && in_ready && enable;
    endsequence

    a_even_centre: assert property (s_acc_en |=> out_valid // RULE4
        && out_i == $past(st_q.ti[2]) && out_q == $past(st_q.tq[2]))
        else $error("even phase is not the centre sample");

    a_second_out: assert property ( // RULE5
        s_acc_en ##1 out_ready |=> out_valid && !in_ready)
        else $error("second interpolated sample missing");

    a_bypass_pass: assert property ( // RULE7
        in_valid && in_ready && !enable |=> out_valid
        && out_i == $past(in_i) && out_q == $past(in_q) && !st_q.pend)
        else $error("bypass sample altered");

    a_hold_stall: assert property ( // RULE1
        out_valid && !out_ready |=> out_valid && $stable(out_i)
        && $stable(out_q))
        else $error("output changed under stall");

endmodule : halfband_interp
`default_nettype wire

// File: logic/interp_halfband_output_router.sv
// six half-band interpolators followed by the output data router
// assumes channel filters upstream and gain loops downstream, one clock
//
// Function
// RULE1: half-band takes and returns rounded 22-bit I/Q
// RULE2: half-band is a fixed eleven-tap FIR
// RULE3: outer taps +14, next pair -66
// RULE4: taps 5,7 are +309, centre +512
// RULE5: two outputs for each input sample
// RULE6: feeding filter stays at or below 17 MHz
// RULE7: interpolation only when control bit 9 set
// RULE8: interleave first, then complex or biphase stage
// RULE9: merged stream carries all member samples
// RULE10: software sets equal taps and phases 0,1
// RULE11: 4-bit stream code selects the grouping
// RULE12: codes 0-4 grow group at channel 0
// RULE13: code 5 two triples, code 6 three pairs
// RULE14: codes 7, 8, 9 mixed groups
// RULE15: complex pair: I=I0-Q1, Q=I1+Q0
// RULE16: 3-bit code 1-3 builds complex pairs
// RULE17: codes 5-7 build biphase pairs
// RULE18: combined result goes to lower stream loop
// RULE19: biphase sums I with I, Q with Q
// RULE20: code 100 means no combining
// RULE21: members emitted in ascending channel order
`timescale 1ns/1ps
`default_nettype none
module interp_halfband_output_router #(
    parameter int NCH = interp_pkg::NCH
) (
    input  wire logic                                  core_clk,
    input  wire logic                                  rst_n,
    input  wire logic [NCH-1:0][interp_pkg::CTL_W-1:0] hb_ctl,
    input  wire logic [interp_pkg::SC_W-1:0]           stream_ctl,
    input  wire logic [interp_pkg::CC_W-1:0]           cplx_ctl,
    input  wire logic [NCH-1:0]                        ch_valid,
    input  wire logic [NCH-1:0][interp_pkg::DW-1:0]    ch_i,
    input  wire logic [NCH-1:0][interp_pkg::DW-1:0]    ch_q,
    output logic [NCH-1:0]                             ch_ready,
    output logic [NCH-1:0]                             agc_valid,
    output logic [NCH-1:0][interp_pkg::DW-1:0]         agc_i,
    output logic [NCH-1:0][interp_pkg::DW-1:0]         agc_q,
    input  wire logic [NCH-1:0]                        agc_ready,
    output logic [NCH-1:0]                             agc_used
);

    if (NCH != 6) begin : g_bad_nch
        $error("grouping table serves exactly six channels");
    end

    localparam int W = interp_pkg::DW;

    typedef struct packed {
        logic [interp_pkg::SC_W-1:0] sc;
        logic [NCH-1:0][2:0]         rr;
        logic [NCH-1:0]              sv;
        logic [NCH-1:0][W-1:0]       si;
        logic [NCH-1:0][W-1:0]       sq;
        logic [NCH-1:0]              v0;
        logic [NCH-1:0]              v1;
        logic [NCH-1:0][W-1:0]       e0i;
        logic [NCH-1:0][W-1:0]       e0q;
        logic [NCH-1:0][W-1:0]       e1i;
        logic [NCH-1:0][W-1:0]       e1q;
        logic [NCH-1:0]              used;
    } rt_s;

    rt_s st_q;
    rt_s st_d;

    logic [NCH-1:0]         hv;
    logic [NCH-1:0]         hr;
    logic [NCH-1:0][W-1:0]  hi;
    logic [NCH-1:0][W-1:0]  hq;
    interp_pkg::size_map_t  sz;
    logic [2:0]             pair;
    logic                   bip;
    logic [NCH-1:0]         push;
    logic [NCH-1:0]         cons;
    logic [NCH-1:0][W-1:0]  pi;
    logic [NCH-1:0][W-1:0]  pq;
    int                     m;

    // per-channel interpolators, enabled by bit 9 of each control word
    for (genvar c = 0; c < NCH; c++) begin : g_hb
        halfband_interp u_hb (
            .core_clk  (core_clk),
            .rst_n     (rst_n),
            .enable    (hb_ctl[c][interp_pkg::HB_EN_BIT]),
            .in_valid  (ch_valid[c]),
            .in_i      (ch_i[c]),
            .in_q      (ch_q[c]),
            .in_ready  (ch_ready[c]),
            .out_valid (hv[c]),
            .out_i     (hi[c]),
            .out_q     (hq[c]),
            .out_ready (hr[c])
        );
    end

    // group size per lead slot, zero for slots merged into a lower one
    function automatic interp_pkg::size_map_t size_map(
        input logic [interp_pkg::SC_W-1:0] code);
        case (code)
            4'h0: size_map = {3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h2}; // RULE12
            4'h1: size_map = {3'h1, 3'h1, 3'h1, 3'h0, 3'h0, 3'h3}; // RULE12
            4'h2: size_map = {3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h4}; // RULE12
            4'h3: size_map = {3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h5}; // RULE12
            4'h4: size_map = {3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h6}; // RULE12
            4'h5: size_map = {3'h0, 3'h0, 3'h3, 3'h0, 3'h0, 3'h3}; // RULE13
            4'h6: size_map = {3'h0, 3'h2, 3'h0, 3'h2, 3'h0, 3'h2}; // RULE13
            4'h7: size_map = {3'h1, 3'h1, 3'h0, 3'h2, 3'h0, 3'h2}; // RULE14
            4'h8: size_map = {3'h1, 3'h0, 3'h2, 3'h0, 3'h0, 3'h3}; // RULE14
            4'h9: size_map = {3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h4}; // RULE14
            default: size_map = {3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1}; // RULE12
        endcase
    endfunction : size_map

    always_comb begin
        sz  = size_map(stream_ctl); // RULE11
        bip = cplx_ctl[interp_pkg::CC_BIP_BIT];
        for (int p = 0; p < 3; p++) begin
            // code 100 gives count zero, so no pair is formed
            pair[p] = (2'(p) < cplx_ctl[1:0]) // RULE16 RULE17 RULE20
                      && sz[2*p] != 3'h0 && sz[2*p+1] != 3'h0;
        end
    end

    always_comb begin
        st_d = st_q;
        hr   = '0;
        push = '0;
        cons = '0;
        pi   = '0;
        pq   = '0;
        m    = 0;
        // second stage: combine pairs or pass streams to the buffers
        for (int k = 0; k < NCH; k++) begin // RULE8
            if (k % 2 == 0 && pair[k/2]) begin
                if (st_q.sv[k] && st_q.sv[k+1] && !st_q.v1[k]) begin
                    push[k]   = 1'b1; // RULE18
                    cons[k]   = 1'b1;
                    cons[k+1] = 1'b1;
                    if (bip) begin
                        pi[k] = interp_pkg::sat( // RULE19
                            interp_pkg::sx(st_q.si[k])
                            + interp_pkg::sx(st_q.si[k+1]));
                        pq[k] = interp_pkg::sat( // RULE19
                            interp_pkg::sx(st_q.sq[k])
                            + interp_pkg::sx(st_q.sq[k+1]));
                    end else begin
                        pi[k] = interp_pkg::sat( // RULE15
                            interp_pkg::sx(st_q.si[k])
                            - interp_pkg::sx(st_q.sq[k+1]));
                        pq[k] = interp_pkg::sat( // RULE15
                            interp_pkg::sx(st_q.si[k+1])
                            + interp_pkg::sx(st_q.sq[k]));
                    end
                end
            end else if (!(k % 2 == 1 && pair[k/2])) begin
                if (st_q.sv[k] && !st_q.v1[k]) begin
                    push[k] = 1'b1;
                    cons[k] = 1'b1;
                    pi[k]   = st_q.si[k];
                    pq[k]   = st_q.sq[k];
                end
            end
        end
        // two-entry buffer per gain loop, head drives the outputs
        for (int k = 0; k < NCH; k++) begin
            if (st_q.v0[k] && agc_ready[k]) begin
                st_d.e0i[k] = st_q.e1i[k];
                st_d.e0q[k] = st_q.e1q[k];
                st_d.v0[k]  = st_q.v1[k];
                st_d.v1[k]  = 1'b0;
            end
            if (push[k]) begin
                if (!st_d.v0[k]) begin
                    st_d.e0i[k] = pi[k];
                    st_d.e0q[k] = pq[k];
                    st_d.v0[k]  = 1'b1;
                end else begin
                    st_d.e1i[k] = pi[k];
                    st_d.e1q[k] = pq[k];
                    st_d.v1[k]  = 1'b1;
                end
            end
        end
        // first stage: round-robin interleave over group members
        for (int k = 0; k < NCH; k++) begin
            if (cons[k]) begin
                st_d.sv[k] = 1'b0;
            end
            m = k + int'(st_q.rr[k]); // RULE21
            if (sz[k] != 3'h0 && !st_d.sv[k] && m < NCH) begin
                if (hv[m]) begin // RULE9
                    hr[m]      = 1'b1;
                    st_d.sv[k] = 1'b1;
                    st_d.si[k] = hi[m];
                    st_d.sq[k] = hq[m];
                    if (st_q.rr[k] + 3'h1 == sz[k]) begin // RULE21
                        st_d.rr[k] = 3'h0;
                    end else begin
                        st_d.rr[k] = st_q.rr[k] + 3'h1;
                    end
                end
            end
            st_d.used[k] = sz[k] != 3'h0 // RULE18
                           && !(k % 2 == 1 && pair[k/2]);
        end
        // a new grouping restarts every group at its lowest channel
        if (stream_ctl != st_q.sc) begin
            st_d.rr = '0; // RULE21
        end
        st_d.sc = stream_ctl;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign agc_valid = st_q.v0;
    assign agc_i     = st_q.e0i;
    assign agc_q     = st_q.e0q;
    assign agc_used  = st_q.used;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_pair0_ready;
        !st_q.v0[0] && pair[0] && st_q.sv[0] && st_q.sv[1];
    endsequence

    a_cplx_math: assert property ( // RULE15
        s_pair0_ready ##0 !bip |=> agc_valid[0]
        && agc_i[0] == interp_pkg::sat(interp_pkg::sx($past(st_q.si[0]))
                       - interp_pkg::sx($past(st_q.sq[1])))
        && agc_q[0] == interp_pkg::sat(interp_pkg::sx($past(st_q.si[1]))
                       + interp_pkg::sx($past(st_q.sq[0]))))
        else $error("complex completion result wrong");

    a_biphase_math: assert property ( // RULE19
        s_pair0_ready ##0 bip |=> agc_valid[0]
        && agc_i[0] == interp_pkg::sat(interp_pkg::sx($past(st_q.si[0]))
                       + interp_pkg::sx($past(st_q.si[1]))))
        else $error("biphase sum wrong");

    a_upper_idle: assert property ( // RULE18
        pair[0] && !st_q.v0[1] && $stable(cplx_ctl) |=> !agc_valid[1])
        else $error("upper stream of a pair was delivered");

    a_rr_next: assert property ( // RULE21
        hr[0] && st_q.rr[0] == 3'h0 && sz[0] > 3'h1
        && stream_ctl == st_q.sc |=> st_q.rr[0] == 3'h1)
        else $error("interleave order not ascending");

    a_full_merge: assert property ( // RULE12
        stream_ctl == 4'h4 && !pair[0] |=> agc_used == 6'h01)
        else $error("all-channel merge uses more than loop 0");

    a_three_pairs: assert property ( // RULE13
        stream_ctl == 4'h6 && cplx_ctl == 3'h0 |=> agc_used == 6'h15)
        else $error("three-pair grouping uses wrong loops");

    a_pair_used: assert property ( // RULE18
        pair[1] |=> !agc_used[3])
        else $error("upper loop of a pair still marked used");

    a_buf_order: assert property ( // RULE9
        st_q.v1 != '0 |-> (st_q.v1 & ~st_q.v0) == '0)
        else $error("buffer tail valid without head");

endmodule : interp_halfband_output_router
`default_nettype wire

// File: tb/gain_loop_model.sv
// gain-loop stand-in: accepts router words and logs {slot, i, q}
// assumes one clock; stall mask and slow pacing come from the bench
`timescale 1ns/1ps
`default_nettype none
module gain_loop_model (
    input  wire logic                           core_clk,
    input  wire logic                           rst_n,
    input  wire logic [5:0]                     stall,
    input  wire logic                           slow,
    input  wire logic [5:0]                     agc_valid,
    input  wire logic [5:0][interp_pkg::DW-1:0] agc_i,
    input  wire logic [5:0][interp_pkg::DW-1:0] agc_q,
    output logic [5:0]                          agc_ready
);
    logic        ph_q;
    logic [46:0] log_w[$];

    // slow mode answers every other cycle, stall holds a loop off
    assign agc_ready = ~stall & {6{~slow | ph_q}};

    always @(posedge core_clk) begin
        if (!rst_n) begin
            ph_q <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
            for (int k = 0; k < 6; k++) begin
                if (agc_valid[k] && agc_ready[k]) begin
                    log_w.push_back({3'(k), agc_i[k], agc_q[k]});
                end
            end
        end
    end
endmodule : gain_loop_model
`default_nettype wire

// File: tb/tb_top.sv
// bench for the half-band interpolators and output router
// assumes the gain-loop model downstream; the bench feeds the channels
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int DLY = 1;
    logic             core_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic [5:0][15:0] hb_ctl = '0;
    logic [3:0]       stream_ctl = 4'hF;
    logic [2:0]       cplx_ctl = 3'h0;
    logic [5:0]       ch_valid = '0;
    logic [5:0][21:0] ch_i = '0;
    logic [5:0][21:0] ch_q = '0;
    logic [5:0]       ch_ready;
    logic [5:0]       agc_valid;
    logic [5:0]       agc_ready;
    logic [5:0]       agc_used;
    logic [5:0][21:0] agc_i;
    logic [5:0][21:0] agc_q;
    logic [5:0]       stall = '0;
    logic             slow = 1'b0;
    int               miscompares = 0;
    int               n_checks = 0;
    logic [46:0]      exp_w[$];

    interp_halfband_output_router #(.NCH(6)) u_interp_halfband_output_router (
        .core_clk(core_clk), .rst_n(rst_n), .hb_ctl(hb_ctl),
        .stream_ctl(stream_ctl), .cplx_ctl(cplx_ctl), .ch_valid(ch_valid),
        .ch_i(ch_i), .ch_q(ch_q), .ch_ready(ch_ready),
        .agc_valid(agc_valid), .agc_i(agc_i), .agc_q(agc_q),
        .agc_ready(agc_ready), .agc_used(agc_used));

    gain_loop_model u_gain_loop_model (
        .core_clk(core_clk), .rst_n(rst_n), .stall(stall), .slow(slow),
        .agc_valid(agc_valid), .agc_i(agc_i), .agc_q(agc_q),
        .agc_ready(agc_ready));

    always #20 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [46:0] e,
                       input logic [46:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #DLY;
    endtask : tick

    // one sample, held valid until ready is seen, then dropped a cycle, so rate stays legal
    task automatic send(input int k, input logic [21:0] i,
                        input logic [21:0] q);
        int n;
        n = 0;
        ch_i[k] = i;
        ch_q[k] = q;
        ch_valid[k] = 1'b1;
        while (ch_ready[k] !== 1'b1) begin
            tick(1);
            n++;
            if (n > 500) begin
                miscompares++;
                close_out();
            end
        end
        tick(1);
        ch_valid[k] = 1'b0;
        ch_i[k] = ~i;
        ch_q[k] = ~q;
        tick(1);
    endtask : send

    task automatic expect_w(input int s, input logic [21:0] i,
                            input logic [21:0] q);
        exp_w.push_back({3'(s), i, q});
    endtask : expect_w

    task automatic drain(input string name, input bit srt);
        int n;
        n = 0;
        while (u_gain_loop_model.log_w.size() < exp_w.size()) begin
            tick(1);
            n++;
            if (n > 2000) begin
                miscompares++;
                close_out();
            end
        end
        tick(8);
        if (srt) begin
            exp_w.sort();
            u_gain_loop_model.log_w.sort();
        end
        chk({name, " count"}, 47'(exp_w.size()),
            47'(u_gain_loop_model.log_w.size()));
        foreach (exp_w[j]) begin
            if (j < u_gain_loop_model.log_w.size()) begin
                chk(name, exp_w[j], u_gain_loop_model.log_w[j]);
            end
        end
        exp_w.delete();
        u_gain_loop_model.log_w.delete();
        $display("test %s done", name);
    endtask : drain

    function automatic logic [21:0] hb_odd(input int h[6]);
        longint a;
        a = 14 * (h[0] + h[5]) - 66 * (h[1] + h[4]) + 309 * (h[2] + h[3]);
        a = (a + 256) >>> 9;
        if (a > 2097151) a = 2097151;
        if (a < -2097152) a = -2097152;
        return 22'(a);
    endfunction : hb_odd

    initial begin
        int vals[8] = '{1000, -777, 3, 2000000, 2000000, -5, 0, 0};
        int hi[6];
        int hq[6];
        logic [5:0] used_sc[16] = '{6'h3D, 6'h39, 6'h31, 6'h21, 6'h01,
            6'h09, 6'h15, 6'h35, 6'h29, 6'h11, 6'h3F, 6'h3F, 6'h3F,
            6'h3F, 6'h3F, 6'h3F};
        logic [5:0] used_cc[8] = '{6'h3F, 6'h3D, 6'h35, 6'h15,
                                   6'h3F, 6'h3D, 6'h35, 6'h15};
        int gc[4] = '{0, 5, 9, 4};
        int gl[4] = '{0, 3, 4, 0};
        int gm[4] = '{2, 3, 2, 6};
        int cc[8] = '{1, 5, 4, 2, 6, 3, 7, 1};
        int cp[8] = '{0, 0, 0, 2, 2, 4, 4, 2};
        logic [21:0] a0;
        logic [21:0] b0;
        logic [21:0] a1;
        logic [21:0] b1;
        tick(5);
        chk("ch_ready in reset", 47'h0, 47'(ch_ready));
        chk("agc_valid in reset", 47'h0, 47'(agc_valid));
        rst_n = 1'b1;
        tick(2);
        chk("ch_ready after reset", 47'h3F, 47'(ch_ready));
        // interpolation on channel 2, slow gain loop
        hi = '{default: 0};
        hq = '{default: 0};
        hb_ctl[2] = 16'h0200;
        slow = 1'b1;
        foreach (vals[n]) begin
            for (int j = 5; j > 0; j--) begin
                hi[j] = hi[j-1];
                hq[j] = hq[j-1];
            end
            hi[0] = vals[n];
            hq[0] = -vals[n];
            send(2, 22'(vals[n]), 22'(-vals[n]));
            expect_w(2, 22'(hi[3]), 22'(hq[3]));
            expect_w(2, hb_odd(hi), hb_odd(hq));
        end
        drain("interp", 1'b0);
        slow = 1'b0;
        hb_ctl = {6{16'hFDFF}};
        send(2, 22'h2ABCDE, 22'h012345);
        expect_w(2, 22'h2ABCDE, 22'h012345);
        drain("bypass", 1'b0);
        // gain-loop usage for every grouping and pairing code
        for (int s = 0; s < 16; s++) begin
            stream_ctl = 4'(s);
            tick(2);
            chk("agc_used stream", 47'(used_sc[s]), 47'(agc_used));
        end
        stream_ctl = 4'hF;
        for (int c = 0; c < 8; c++) begin
            cplx_ctl = 3'(c);
            tick(2);
            chk("agc_used cplx", 47'(used_cc[c]), 47'(agc_used));
        end
        $display("test used done");
        // interleaving; equal-phase channels stand in for phases 0 and 1
        cplx_ctl = 3'h0;
        for (int t = 0; t < 4; t++) begin
            stream_ctl = 4'(gc[t]);
            tick(2);
            for (int j = 0; j < gm[t]; j++) begin
                fork
                    automatic int c = gl[t] + j;
                    send(c, 22'(c * 4096 + 5), 22'(c + 7));
                join_none
                expect_w(gl[t], 22'((gl[t] + j) * 4096 + 5),
                         22'(gl[t] + j + 7));
            end
            wait fork;
            drain("interleave", 1'b0);
        end
        // complex and biphase on each pair, none on the pairs at channels 0 and 2
        stream_ctl = 4'hF;
        a0 = 22'h001234;
        b0 = 22'h3FF000;
        a1 = 22'h000321;
        b1 = 22'h002000;
        for (int t = 0; t < 8; t++) begin
            cplx_ctl = 3'(cc[t]);
            tick(2);
            fork
                send(cp[t], a0, b0);
                send(cp[t] + 1, a1, b1);
            join
            if (cc[t] != 4 && (cc[t] % 4) > cp[t] / 2) begin
                if (cc[t] > 4) begin
                    expect_w(cp[t], a0 + a1, b0 + b1);
                end else begin
                    expect_w(cp[t], a0 - b1, a1 + b0);
                end
            end else begin
                expect_w(cp[t], a0, b0);
                expect_w(cp[t] + 1, a1, b1);
            end
            drain("combine", 1'b1);
        end
        // stalled gain loop: buffer fills, channel refuses, nothing lost
        cplx_ctl = 3'h0;
        stall = 6'h01;
        tick(2);
        fork
            for (int n = 0; n < 6; n++) begin
                send(0, 22'(n * 3 + 1), 22'(n * 5 + 2));
            end
        join_none
        for (int n = 0; n < 6; n++) begin
            expect_w(0, 22'(n * 3 + 1), 22'(n * 5 + 2));
        end
        tick(40);
        chk("ch_ready stalled", 47'h0, 47'(ch_ready[0]));
        chk("agc_valid stalled", 47'h1, 47'(agc_valid[0]));
        stall = 6'h00;
        wait fork;
        drain("stall", 1'b0);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
